// >>> design/xtse_cfg.svh
`ifndef XTSE_CFG_SVH
`define XTSE_CFG_SVH
// Opcode match patterns and masks on the 12-bit word
`define OPC_DIR_MASK 12'hf_f8
`define OPC_DIR_VAL 12'h0_00
`define OPC_LXOR_MASK 12'hf_00
`define OPC_LXOR_VAL 12'hf_00
`define OPC_RXOR_MASK 12'hf_c0
`define OPC_RXOR_VAL 12'h1_80
`define OPC_RSUB_MASK 12'hf_c0
`define OPC_RSUB_VAL 12'h0_80
`define OPC_SWAP_MASK 12'hf_c0
`define OPC_SWAP_VAL 12'h3_80
`define DEST_BIT 5
`define PORT_FIRST 3'h5
`define PORT_LAST 3'h7
`define ACC_RST 8'h00
`define DIR_RST 8'hff
`endif

// >>> design/xtse_pkg.sv
package xtse_pkg;
    typedef enum logic [5:0] {
        OP_NONE = 6'b00_0001,
        OP_DIR = 6'b00_0010,
        OP_LXOR = 6'b00_0100,
        OP_RXOR = 6'b00_1000,
        OP_RSUB = 6'b01_0000,
        OP_SWAP = 6'b10_0000
    } op_t;
    typedef struct packed {
        logic z;
        logic dc;
        logic c;
    } flags_t;
    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } file_wr_t;
endpackage

// >>> design/op_decode.sv
`include "xtse_cfg.svh"
module op_decode (
    input wire logic [11:0] word,
    output xtse_pkg::op_t op
);
    function automatic logic hit(input logic [11:0] w, input logic [11:0] m, input logic [11:0] v);
        hit = (w & m) == v;
    endfunction
    wire is_dir = hit(word, `OPC_DIR_MASK, `OPC_DIR_VAL) && word[2:0] >= `PORT_FIRST;
    wire is_lxor = hit(word, `OPC_LXOR_MASK, `OPC_LXOR_VAL);
    wire is_rxor = hit(word, `OPC_RXOR_MASK, `OPC_RXOR_VAL);
    wire is_rsub = hit(word, `OPC_RSUB_MASK, `OPC_RSUB_VAL);
    wire is_swap = hit(word, `OPC_SWAP_MASK, `OPC_SWAP_VAL);
    assign op = is_dir ? xtse_pkg::OP_DIR :
                is_lxor ? xtse_pkg::OP_LXOR :
                is_rxor ? xtse_pkg::OP_RXOR :
                is_rsub ? xtse_pkg::OP_RSUB :
                is_swap ? xtse_pkg::OP_SWAP : xtse_pkg::OP_NONE;
endmodule

// >>> design/xor_port_direction_load_sub_execute.sv
// What this block does
// - Direction load copies accumulator to port 5-7
// - Direction load: upper nine bits zero
// - Literal XOR into accumulator, zero flag only
// - Register XOR with accumulator, zero flag only
// - Destination bit picks accumulator or register
// - Carry clear on borrow, set otherwise
// - Subtract register minus accumulator, C DC Z
// - Nibble exchange, flags unchanged
`include "xtse_cfg.svh"
module xor_port_direction_load_sub_execute (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic exec_en,
    input wire logic [11:0] word,
    input wire logic [7:0] file_rdata,
    input wire xtse_pkg::flags_t flags_in,
    output logic [4:0] file_raddr,
    output xtse_pkg::file_wr_t file_wr_ff,
    output xtse_pkg::flags_t flags_ff,
    output logic [7:0] acc_ff,
    output logic [7:0] dir5_ff,
    output logic [7:0] dir6_ff,
    output logic [7:0] dir7_ff,
    output logic known_op
);
    xtse_pkg::op_t op;
    op_decode u_dec (
        .word(word),
        .op(op)
    );
    assign known_op = op != xtse_pkg::OP_NONE;
    assign file_raddr = word[4:0];
    wire to_reg = word[`DEST_BIT];
    wire go = exec_en && known_op;
    wire [8:0] diff = {1'b0, file_rdata} - {1'b0, acc_ff};
    wire [4:0] ldiff = {1'b0, file_rdata[3:0]} - {1'b0, acc_ff[3:0]};
    wire [7:0] swapped = {file_rdata[3:0], file_rdata[7:4]};
    logic [7:0] result;
    always_comb begin
        case (op)
            xtse_pkg::OP_LXOR: result = acc_ff ^ word[7:0];
            xtse_pkg::OP_RXOR: result = acc_ff ^ file_rdata;
            xtse_pkg::OP_RSUB: result = diff[7:0];
            xtse_pkg::OP_SWAP: result = swapped;
            default: result = acc_ff;
        endcase
    end
    wire writes_data = op == xtse_pkg::OP_RXOR || op == xtse_pkg::OP_RSUB || op == xtse_pkg::OP_SWAP;
    wire nxt_to_acc = go && (op == xtse_pkg::OP_LXOR || (writes_data && !to_reg));
    wire nxt_to_reg = go && writes_data && to_reg;
    xtse_pkg::flags_t nxt_flags;
    always_comb begin
        nxt_flags = flags_in;
        if (go && (op == xtse_pkg::OP_LXOR || op == xtse_pkg::OP_RXOR || op == xtse_pkg::OP_RSUB)) begin
            nxt_flags.z = result == 8'h00;
        end
        if (go && op == xtse_pkg::OP_RSUB) begin
            nxt_flags.c = ~diff[8];
            nxt_flags.dc = ~ldiff[4];
        end
    end
    wire ld5 = go && op == xtse_pkg::OP_DIR && word[2:0] == 3'h5;
    wire ld6 = go && op == xtse_pkg::OP_DIR && word[2:0] == 3'h6;
    wire ld7 = go && op == xtse_pkg::OP_DIR && word[2:0] == `PORT_LAST;

    // Accumulator only moves on a result aimed at it
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            acc_ff <= `ACC_RST;
        end else if (nxt_to_acc) begin
            acc_ff <= result;
        end
    end

    // Flags follow the core unless an instruction changes them
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Write request lasts one cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            file_wr_ff <= '0;
        end else begin
            file_wr_ff <= '{we: nxt_to_reg, addr: word[4:0], data: result};
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dir5_ff <= `DIR_RST;
        end else if (ld5) begin
            dir5_ff <= acc_ff;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dir6_ff <= `DIR_RST;
        end else if (ld6) begin
            dir6_ff <= acc_ff;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dir7_ff <= `DIR_RST;
        end else if (ld7) begin
            dir7_ff <= acc_ff;
        end
    end

    // Direction loads
    a_dir_load: assert property (@(posedge mclk) disable iff (!rstn)
        ld6 |=> dir6_ff == $past(acc_ff)) else $error("direction load wrong");
    a_dir5_load: assert property (@(posedge mclk) disable iff (!rstn)
        ld5 |=> dir5_ff == $past(acc_ff)) else $error("direction five load wrong");
    a_dir7_load: assert property (@(posedge mclk) disable iff (!rstn)
        ld7 |=> dir7_ff == $past(acc_ff)) else $error("direction seven load wrong");
    a_dir_low_port: assert property (@(posedge mclk) disable iff (!rstn)
        (exec_en && word[11:3] == 9'h000 && word[2:0] < 3'h5) |=> $stable(dir5_ff) && $stable(dir6_ff)
        && $stable(dir7_ff)) else $error("low port changed a direction register");
    a_dir_side_effect: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_DIR) |=> $stable(acc_ff) && !file_wr_ff.we)
        else $error("direction load disturbed accumulator or file");

    // Decode
    a_dir_decode: assert property (@(posedge mclk) disable iff (!rstn)
        (exec_en && word[11:3] != 9'h000 && word[11:8] != 4'hf) |=> $stable(dir5_ff))
        else $error("direction changed by other word");
    a_dir_other_hold: assert property (@(posedge mclk) disable iff (!rstn)
        (exec_en && word[11:3] != 9'h000) |=> $stable(dir6_ff) && $stable(dir7_ff))
        else $error("direction six or seven changed by other word");
    a_dir_known: assert property (@(posedge mclk) disable iff (!rstn)
        (word[11:3] == 9'h000 && word[2:0] >= 3'h5) |-> known_op)
        else $error("direction load not recognised");
    a_unknown_idle: assert property (@(posedge mclk) disable iff (!rstn)
        (exec_en && !known_op) |=> !file_wr_ff.we && $stable(acc_ff) && flags_ff == $past(flags_in))
        else $error("unknown word had an effect");

    // Literal exclusive-or
    a_lxor_acc: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_LXOR) |=> acc_ff == ($past(acc_ff) ^ $past(word[7:0]))
        && flags_ff.c == $past(flags_in.c)) else $error("literal xor wrong");
    a_lxor_zero: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_LXOR) |=> flags_ff.z == (($past(acc_ff) ^ $past(word[7:0])) == 8'h00)
        && flags_ff.dc == $past(flags_in.dc)) else $error("literal xor flags wrong");
    a_lxor_no_write: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_LXOR) |=> !file_wr_ff.we) else $error("literal xor wrote the file");

    // Register exclusive-or, subtract and destination
    a_rxor_zero: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_RXOR) |=> flags_ff.z == ($past(acc_ff) == $past(file_rdata)))
        else $error("register xor zero flag wrong");
    a_rxor_flags: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_RXOR) |=> flags_ff.c == $past(flags_in.c) && flags_ff.dc == $past(flags_in.dc))
        else $error("register xor touched carry flags");
    a_rxor_data: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_RXOR && to_reg) |=> file_wr_ff.data == ($past(acc_ff) ^ $past(file_rdata))
        && file_wr_ff.addr == $past(word[4:0])) else $error("register xor write wrong");
    a_dest_acc: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_RXOR && !to_reg) |=> !file_wr_ff.we
        && acc_ff == ($past(acc_ff) ^ $past(file_rdata))) else $error("accumulator destination wrong");
    a_dest_reg: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_RXOR && to_reg) |=> file_wr_ff.we && $stable(acc_ff))
        else $error("destination not honoured");
    a_sub_carry: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_RSUB) |=> flags_ff.c == ($past(file_rdata) >= $past(acc_ff)))
        else $error("borrow carry wrong");
    a_sub_value: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_RSUB && !to_reg) |=> acc_ff == 8'($past(file_rdata) - $past(acc_ff)))
        else $error("subtract result wrong");
    a_sub_dest_reg: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_RSUB && to_reg) |=> file_wr_ff.we && $stable(acc_ff)
        && file_wr_ff.data == 8'($past(file_rdata) - $past(acc_ff))) else $error("subtract write wrong");
    a_sub_zero: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_RSUB) |=> flags_ff.z == ($past(file_rdata) == $past(acc_ff)))
        else $error("subtract zero flag wrong");
    a_sub_digit: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_RSUB) |=> flags_ff.dc == ($past(file_rdata[3:0]) >= $past(acc_ff[3:0])))
        else $error("subtract digit carry wrong");

    // Nibble exchange
    a_swap_flags: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_SWAP) |=> flags_ff == $past(flags_in)
        && file_wr_ff.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}) else $error("swap wrong");
    a_swap_acc: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_SWAP && !to_reg) |=> acc_ff == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("swap into accumulator wrong");
    a_swap_reg: assert property (@(posedge mclk) disable iff (!rstn)
        (go && op == xtse_pkg::OP_SWAP && to_reg) |=> file_wr_ff.we && $stable(acc_ff)
        && file_wr_ff.addr == $past(word[4:0])) else $error("swap into register wrong");

    // Timing
    a_one_cycle: assert property (@(posedge mclk) disable iff (!rstn)
        (go && writes_data && to_reg) |=> file_wr_ff.we ##1 (!file_wr_ff.we || $past(go && writes_data && to_reg)))
        else $error("write not single cycle");
    a_wr_cause: assert property (@(posedge mclk) disable iff (!rstn)
        file_wr_ff.we |-> $past(go && writes_data && to_reg)) else $error("write without instruction");

    // Main scenarios
    c_dir: cover property (@(posedge mclk) disable iff (!rstn) ld7);
    c_sub_borrow: cover property (@(posedge mclk) disable iff (!rstn) go && op == xtse_pkg::OP_RSUB && diff[8]);
    c_xor_zero: cover property (@(posedge mclk) disable iff (!rstn) go && op == xtse_pkg::OP_RXOR && result == 8'h00);
    c_swap_reg: cover property (@(posedge mclk) disable iff (!rstn) go && op == xtse_pkg::OP_SWAP && to_reg);
    c_lxor: cover property (@(posedge mclk) disable iff (!rstn) go && op == xtse_pkg::OP_LXOR);
endmodule

// >>> tb/file_model.sv
module file_model (
    input wire logic mclk,
    input wire logic [4:0] file_raddr,
    input wire xtse_pkg::file_wr_t file_wr_ff,
    output logic [7:0] file_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [32];
    initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 29);
    // Pending write is forwarded so back-to-back reads see it
    assign file_rdata = (file_wr_ff.we && file_wr_ff.addr == file_raddr) ? file_wr_ff.data : mem[file_raddr];
    always @(posedge mclk) if (file_wr_ff.we) mem[file_wr_ff.addr] <= file_wr_ff.data;
endmodule

// >>> tb/xor_port_direction_load_sub_execute_bench.sv
module xor_port_direction_load_sub_execute_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 0, rstn = 0, exec_en = 0, known_op, rop, kn;
    logic [11:0] word = 12'h000;
    xtse_pkg::flags_t flags_in = 3'h0, flags_ff, fl;
    xtse_pkg::file_wr_t file_wr_ff, wr;
    logic [4:0] file_raddr;
    logic [7:0] file_rdata, acc_ff, dir5_ff, dir6_ff, dir7_ff, acc = 8'h00, f, res;
    logic [7:0] mem [32];
    logic [23:0] dirs = 24'hff_ffff;
    logic [48:0] notes [$];
    logic [48:0] n;
    logic [31:0] rng = 32'h0000_5e3a;
    int fails = 0, cmp_count = 0, cycles = 0;
    xor_port_direction_load_sub_execute uut (.mclk(mclk), .rstn(rstn), .exec_en(exec_en), .word(word),
        .file_rdata(file_rdata), .flags_in(flags_in), .file_raddr(file_raddr), .file_wr_ff(file_wr_ff),
        .flags_ff(flags_ff), .acc_ff(acc_ff), .dir5_ff(dir5_ff), .dir6_ff(dir6_ff), .dir7_ff(dir7_ff),
        .known_op(known_op));
    file_model partner (.mclk(mclk), .file_raddr(file_raddr), .file_wr_ff(file_wr_ff), .file_rdata(file_rdata));
    initial forever #12.5 mclk = ~mclk;
    function logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task conclude;
        if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            fails++;
            conclude;
        end
    end
    // Oldest note against what the block shows one edge later
    always begin
        @(posedge mclk);
        #1;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            cmp_count++;
            if ({acc_ff, flags_ff, dir7_ff, dir6_ff, dir5_ff} !== {n[48:38], n[23:0]}
                    || file_wr_ff.we !== n[37] || (n[37] && file_wr_ff !== n[37:24])) begin
                fails++;
                $display("FAIL %0t result mismatch word %h", $time, word);
            end
        end
    end
    initial begin
        for (int i = 0; i < 32; i++) mem[i] = 8'(i * 29);
        repeat (20) @(posedge mclk);
        @(negedge mclk) rstn = 1;
        repeat (600) begin
            rng = xs(rng);
            exec_en = rng[31:29] != 3'h0;
            flags_in = rng[2:0];
            case (rng[28:26])
                3'h0: word = {4'hf, rng[17] ? acc : rng[10:3]};
                3'h1: word = {6'h06, rng[8:3]};
                3'h2: word = {6'h02, rng[8:3]};
                3'h3: word = {6'h0e, rng[8:3]};
                3'h4: word = {9'h000, rng[5:3]};
                default: word = rng[14:3];
            endcase
            f = mem[word[4:0]];
            fl = flags_in;
            rop = 0;
            res = acc;
            if (exec_en) casez (word)
                12'b0000_0000_0???: if (word[2:0] >= 3'h5) dirs[8 * (int'(word[2:0]) - 5) +: 8] = acc;
                12'b1111_????_????: begin
                    acc = acc ^ word[7:0];
                    fl.z = acc == 8'h00;
                end
                12'b0001_10??_????: begin
                    res = acc ^ f;
                    fl.z = res == 8'h00;
                    rop = 1;
                end
                12'b0000_10??_????: begin
                    res = f - acc;
                    fl = {res == 8'h00, f[3:0] >= acc[3:0], f >= acc};
                    rop = 1;
                end
                12'b0011_10??_????: begin
                    res = {f[3:0], f[7:4]};
                    rop = 1;
                end
                default: ;
            endcase
            wr = {rop && word[5], word[4:0], res};
            if (wr.we) mem[word[4:0]] = res;
            else if (rop) acc = res;
            notes.push_back({acc, fl, wr, dirs});
            kn = (word[11:3] == 9'h000 && word[2:0] >= 3'h5) || word[11:8] == 4'hf
                || word[11:6] == 6'h06 || word[11:6] == 6'h02 || word[11:6] == 6'h0e;
            #1;
            cmp_count++;
            if (known_op !== kn || file_raddr !== word[4:0]) begin
                fails++;
                $display("FAIL %0t decode mismatch word %h", $time, word);
            end
            @(negedge mclk);
        end
        repeat (2) @(negedge mclk);
        conclude;
    end
endmodule
